//--- core/usfc_core.sv
// serial clock generator, frame transmitter and receiver with register slave
// Functional notes
// - four clock modes; sync_mode_select one picks synchronous, zero asynchronous
// - in sync mode pin direction picks master (output) or slave (input) clock
// - transfer clock pin untouched by serial logic in asynchronous mode
// - baud down-counter reloads at zero and on low divisor write; tick at zero
// - divisor is 12 bits from high and low registers, 0 to 4095
// - transmitter divides baud tick by 16, 8 or 2 per mode
// - bit rate fosc/(16,8 or 2 times divisor plus one) per mode
// - receiver uses baud tick directly, 16, 8 or 2 states per mode
// - double speed receiver takes 8 samples per bit instead of 16
// - slave clock synchronised and edge detected; partner keeps it under fosc/4
// - data changes on one clock edge, sampled on the other, polarity selects
// - one start, 5 to 9 data, none/even/odd parity, 1 or 2 stops
// - start, data lsb first, parity, stops; frames may follow back to back
// - stop bits and idle line are high
// - frame format shared by both directions; change only when idle
// - receiver checks only the first stop bit for framing error
// - parity is xor of data bits, inverted for odd
// - receiver flags framing, overrun and parity errors
// - receive buffer holds two characters behind the shift register
// - one transmit buffer ahead of shift register allows gapless frames
// - three event outputs: tx complete, tx buffer empty, rx complete
// - asynchronous receiver majority-filters samples and rejects false starts
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module usfc_core (
  // clock, reset, enable
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // serial link
  input wire logic SERIAL_IN_I,
  output logic SERIAL_OUT_O,
  input wire logic XFER_CLOCK_I,
  output logic XFER_CLOCK_O,
  output logic XFER_CLOCK_OE_N_O,
  // event levels
  output logic TX_COMPLETE_O,
  output logic TX_EMPTY_O,
  output logic RX_COMPLETE_O
);

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic rd_pop;
    logic [usfc_pkg::DIV_W-1:0] cnt;
    logic [usfc_pkg::DIV_W-1:0] div;
    logic [3:0] bhi;
    logic u2x;
    logic xdir;
    logic rxen;
    logic txen;
    logic [2:0] csz;
    logic txb8;
    logic sync;
    logic [1:0] pm;
    logic sbs;
    logic pol;
    logic [3:0] txpre;
    logic xck;
    logic xck_oe_n;
    logic xs1;
    logic xs2;
    logic xs3;
    usfc_pkg::usfc_tx_t tst;
    logic [8:0] tsh;
    logic tpar;
    logic [3:0] tbit;
    logic tstop;
    logic [8:0] tbuf;
    logic tbufv;
    logic txd;
    logic txc;
    logic udre;
    usfc_pkg::usfc_rx_t rst;
    logic [3:0] rcnt;
    logic [2:0] smp;
    logic [8:0] rsh;
    logic [3:0] rbit;
    logic rpar;
    logic rpe;
    logic [1:0][usfc_pkg::ENT_W-1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] fcnt;
    logic dor;
    logic rxc;
  } usfc_state_t;

  usfc_state_t s;
  usfc_state_t n;

  logic tick;
  logic [3:0] rate;
  logic [3:0] mid;
  logic [3:0] nbits;
  logic rise;
  logic fall;
  logic tx_bit;
  logic rx_samp;
  logic bitv;
  logic req;
  logic accept;
  logic wr_ok;
  logic txc_set;
  logic [usfc_pkg::ENT_W-1:0] head;
  logic [7:0] rd_byte;

  always_comb
  begin
    n = s;
    txc_set = 1'b0;
    tick = (s.cnt == '0);
    rate = s.u2x ? usfc_pkg::RATE_DBL : usfc_pkg::RATE_NORM;
    mid = s.u2x ? usfc_pkg::MID_DBL : usfc_pkg::MID_NORM;
    nbits = usfc_pkg::usfc_nbits(s.csz);
    head = (s.fcnt != 2'h0) ? s.fifo[s.rp] : '0;
    req = AVS_READ_I | AVS_WRITE_I;
    accept = req & ~s.wreq;
    wr_ok = accept & AVS_WRITE_I & AVS_BYTEENABLE_I[0];

    // baud generator
    n.cnt = tick ? s.div : s.cnt - 1'b1;
    if (tick)
    begin
      n.txpre = (s.txpre >= rate) ? 4'h0 : s.txpre + 4'h1;
      n.smp = {s.smp[1:0], SERIAL_IN_I};
    end

    // transfer clock: driven only in sync master, sampled only in sync slave
    n.xs1 = XFER_CLOCK_I;
    n.xs2 = s.xs1;
    n.xs3 = s.xs2;
    n.xck_oe_n = ~(s.sync & s.xdir);
    if (s.sync && s.xdir)
    begin
      n.xck = tick ? ~s.xck : s.xck;
    end
    else
    begin
      n.xck = 1'b0;
    end
    rise = s.xdir ? (tick & ~s.xck) : (s.xs2 & ~s.xs3);
    fall = s.xdir ? (tick & s.xck) : (~s.xs2 & s.xs3);
    // async bit period counts 16 or 8 ticks; sync uses clock edges
    tx_bit = s.sync ? (s.pol ? fall : rise)
                    : (tick & (s.txpre >= rate));
    rx_samp = s.sync ? (s.pol ? rise : fall)
                     : (tick & (s.rcnt == mid));
    // majority of three samples filters short glitches
    bitv = s.sync ? SERIAL_IN_I
         : ((s.smp[0] & s.smp[1]) | (s.smp[1] & s.smp[2])
            | (s.smp[0] & s.smp[2]));

    // transmitter
    case (s.tst)
      usfc_pkg::TX_IDLE, usfc_pkg::TX_LAST:
      begin
        if (tx_bit)
        begin
          if (s.tbufv && s.txen)
          begin
            n.txd = 1'b0;
            n.tsh = s.tbuf;
            n.tpar = usfc_pkg::usfc_parity(s.tbuf, nbits, s.pm[0]);
            n.tbufv = 1'b0;
            n.tbit = 4'h0;
            n.tst = usfc_pkg::TX_DATA;
          end
          else
          begin
            n.txd = 1'b1;
            txc_set = (s.tst == usfc_pkg::TX_LAST);
            n.tst = usfc_pkg::TX_IDLE;
          end
        end
      end
      usfc_pkg::TX_DATA:
      begin
        if (tx_bit)
        begin
          n.txd = s.tsh[0];
          n.tsh = {1'b0, s.tsh[8:1]};
          n.tbit = s.tbit + 4'h1;
          if (s.tbit == nbits - 4'h1)
          begin
            n.tst = s.pm[1] ? usfc_pkg::TX_PAR : usfc_pkg::TX_STOP;
            n.tstop = 1'b0;
          end
        end
      end
      usfc_pkg::TX_PAR:
      begin
        if (tx_bit)
        begin
          n.txd = s.tpar;
          n.tst = usfc_pkg::TX_STOP;
        end
      end
      usfc_pkg::TX_STOP:
      begin
        if (tx_bit)
        begin
          n.txd = 1'b1;
          n.tstop = 1'b1;
          if (s.tstop == s.sbs)
          begin
            n.tst = usfc_pkg::TX_LAST;
          end
        end
      end
      default:
      begin
        n.tst = usfc_pkg::TX_IDLE;
        n.txd = 1'b1;
      end
    endcase

    // receiver
    if (s.rst != usfc_pkg::RX_IDLE && tick)
    begin
      n.rcnt = (s.rcnt >= rate) ? 4'h0 : s.rcnt + 4'h1;
    end
    case (s.rst)
      usfc_pkg::RX_IDLE:
      begin
        n.rsh = '0;
        n.rpar = 1'b0;
        n.rpe = 1'b0;
        n.rbit = 4'h0;
        if (s.rxen && s.sync && rx_samp && !SERIAL_IN_I)
        begin
          n.rst = usfc_pkg::RX_DATA;
        end
        else if (s.rxen && !s.sync && tick && !SERIAL_IN_I)
        begin
          n.rcnt = 4'h1;
          n.rst = usfc_pkg::RX_START;
        end
      end
      usfc_pkg::RX_START:
      begin
        if (rx_samp)
        begin
          n.rst = bitv ? usfc_pkg::RX_IDLE : usfc_pkg::RX_DATA;
        end
      end
      usfc_pkg::RX_DATA:
      begin
        if (rx_samp)
        begin
          n.rsh[s.rbit] = bitv;
          n.rpar = s.rpar ^ bitv;
          n.rbit = s.rbit + 4'h1;
          if (s.rbit == nbits - 4'h1)
          begin
            n.rst = s.pm[1] ? usfc_pkg::RX_PAR : usfc_pkg::RX_STOP;
          end
        end
      end
      usfc_pkg::RX_PAR:
      begin
        if (rx_samp)
        begin
          n.rpe = bitv ^ s.rpar ^ s.pm[0];
          n.rst = usfc_pkg::RX_STOP;
        end
      end
      usfc_pkg::RX_STOP:
      begin
        // second stop bit is never looked at
        if (rx_samp)
        begin
          n.rst = usfc_pkg::RX_IDLE;
          if (s.fcnt == usfc_pkg::FIFO_DEPTH)
          begin
            n.dor = 1'b1;
          end
          else
          begin
            n.fifo[s.wp] = {s.rpe, ~bitv, s.rsh};
            n.wp = ~s.wp;
            n.fcnt = s.fcnt + 2'h1;
          end
        end
      end
      default:
      begin
        n.rst = usfc_pkg::RX_IDLE;
      end
    endcase

    // register slave: answer one cycle after the request appears
    case (AVS_ADDRESS_I)
      usfc_pkg::OFS_DATA: rd_byte = head[7:0];
      usfc_pkg::OFS_CTRL_A: rd_byte = {s.rxc, s.txc, s.udre, head[9],
                                       s.dor, head[10], s.u2x, 1'b0};
      usfc_pkg::OFS_CTRL_B: rd_byte = {2'h0, s.xdir, s.rxen, s.txen,
                                       s.csz[2], head[8], s.txb8};
      usfc_pkg::OFS_CTRL_C: rd_byte = {1'b0, s.sync, s.pm, s.sbs,
                                       s.csz[1:0], s.pol};
      usfc_pkg::OFS_BAUD_L: rd_byte = s.div[7:0];
      usfc_pkg::OFS_BAUD_H: rd_byte = {4'h0, s.bhi};
      default: rd_byte = 8'h00;
    endcase
    if (req && s.wreq)
    begin
      n.wreq = 1'b0;
      n.rdata = AVS_READ_I ? {24'h0, rd_byte} : 32'h0;
      n.rd_pop = AVS_READ_I && (AVS_ADDRESS_I == usfc_pkg::OFS_DATA)
                 && (s.fcnt != 2'h0);
    end
    else
    begin
      n.wreq = 1'b1;
    end
    if (accept && s.rd_pop)
    begin
      n.rp = ~s.rp;
      n.fcnt = n.fcnt - 2'h1;
      // an overrun in the same cycle as the pop still sets the flag
      n.dor = (s.rst == usfc_pkg::RX_STOP) && rx_samp
              && (s.fcnt == usfc_pkg::FIFO_DEPTH);
    end
    if (wr_ok)
    begin
      case (AVS_ADDRESS_I)
        usfc_pkg::OFS_DATA:
        begin
          // a write while the buffer is still full is dropped
          if (!s.tbufv)
          begin
            n.tbuf = {s.txb8, AVS_WRITEDATA_I[7:0]};
            n.tbufv = 1'b1;
          end
        end
        usfc_pkg::OFS_CTRL_A:
        begin
          n.u2x = AVS_WRITEDATA_I[usfc_pkg::A_DBL];
          if (AVS_WRITEDATA_I[usfc_pkg::A_TXC])
          begin
            n.txc = 1'b0;
          end
        end
        usfc_pkg::OFS_CTRL_B:
        begin
          n.xdir = AVS_WRITEDATA_I[usfc_pkg::B_XDIR];
          n.rxen = AVS_WRITEDATA_I[usfc_pkg::B_RXEN];
          n.txen = AVS_WRITEDATA_I[usfc_pkg::B_TXEN];
          n.csz[2] = AVS_WRITEDATA_I[usfc_pkg::B_CSZ2];
          n.txb8 = AVS_WRITEDATA_I[usfc_pkg::B_TXB8];
        end
        usfc_pkg::OFS_CTRL_C:
        begin
          // shared by both directions, so a change mid-frame corrupts it
          n.sync = AVS_WRITEDATA_I[usfc_pkg::C_SYNC];
          n.pm = AVS_WRITEDATA_I[usfc_pkg::C_PM +: 2];
          n.sbs = AVS_WRITEDATA_I[usfc_pkg::C_SBS];
          n.csz[1:0] = AVS_WRITEDATA_I[usfc_pkg::C_CSZ +: 2];
          n.pol = AVS_WRITEDATA_I[usfc_pkg::C_POL];
        end
        usfc_pkg::OFS_BAUD_L:
        begin
          n.div = {s.bhi, AVS_WRITEDATA_I[7:0]};
          n.cnt = {s.bhi, AVS_WRITEDATA_I[7:0]};
        end
        usfc_pkg::OFS_BAUD_H:
        begin
          n.bhi = AVS_WRITEDATA_I[3:0];
        end
        default:
        begin
          n.bhi = s.bhi;
        end
      endcase
    end
    // hardware set beats software clear
    if (txc_set)
    begin
      n.txc = 1'b1;
    end
    n.udre = ~n.tbufv;
    n.rxc = (n.fcnt != 2'h0);
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      s <= '0;
      s.wreq <= 1'b1;
      s.div <= usfc_pkg::DIV_RST;
      s.cnt <= usfc_pkg::DIV_RST;
      s.csz <= usfc_pkg::CSZ_RST;
      s.xck_oe_n <= 1'b1;
      s.tst <= usfc_pkg::TX_IDLE;
      s.txd <= 1'b1;
      s.udre <= 1'b1;
      s.rst <= usfc_pkg::RX_IDLE;
      s.smp <= 3'h7;
    end
    else if (CE_I)
    begin
      s <= n;
    end
  end

  assign AVS_READDATA_O = s.rdata;
  assign AVS_WAITREQUEST_O = s.wreq;
  assign SERIAL_OUT_O = s.txd;
  assign XFER_CLOCK_O = s.xck;
  assign XFER_CLOCK_OE_N_O = s.xck_oe_n;
  assign TX_COMPLETE_O = s.txc;
  assign TX_EMPTY_O = s.udre;
  assign RX_COMPLETE_O = s.rxc;

  default clocking usfc_cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);

  baud_reload_a: assert property (
    CE_I && tick && !wr_ok |=> s.cnt == $past(s.div))
    else $error("baud counter did not reload at zero");
  div_load_a: assert property (
    CE_I && wr_ok && AVS_ADDRESS_I == usfc_pkg::OFS_BAUD_L
    |=> s.div == {$past(s.bhi), $past(AVS_WRITEDATA_I[7:0])}
        && s.cnt == s.div)
    else $error("divisor not loaded with low byte write");
  xck_async_a: assert property (
    !s.sync |-> ##1 (s.xck_oe_n && !s.xck) [*2])
    else $error("transfer clock driven in asynchronous mode");
  xck_master_a: assert property (
    CE_I && s.sync && s.xdir && $stable(s.sync) |=> !s.xck_oe_n)
    else $error("master did not drive transfer clock");
  stop_high_a: assert property (
    s.tst == usfc_pkg::TX_LAST || s.tst == usfc_pkg::TX_IDLE
    |-> s.txd)
    else $error("line low outside a frame");
  start_low_a: assert property (
    CE_I && s.tst == usfc_pkg::TX_IDLE && tx_bit && s.tbufv && s.txen
    |=> !s.txd && s.tst == usfc_pkg::TX_DATA && !s.tbufv)
    else $error("start bit not sent");
  parity_out_a: assert property (
    CE_I && s.tst == usfc_pkg::TX_PAR && tx_bit
    |=> s.txd == $past(s.tpar) && s.tst == usfc_pkg::TX_STOP)
    else $error("parity bit wrong");
  fifo_depth_a: assert property (
    s.fcnt <= usfc_pkg::FIFO_DEPTH && (s.rxc == (s.fcnt != 2'h0)))
    else $error("receive buffer count out of range");
  overrun_a: assert property (
    CE_I && s.rst == usfc_pkg::RX_STOP && rx_samp
    && s.fcnt == usfc_pkg::FIFO_DEPTH |=> s.dor)
    else $error("overrun not flagged");
  wait_ans_a: assert property (
    CE_I && req && s.wreq |=> !s.wreq)
    else $error("bus answer late");

  frame_sent_c: cover property (s.tst == usfc_pkg::TX_LAST && txc_set);
  char_recv_c: cover property (s.rst == usfc_pkg::RX_STOP && rx_samp);
  false_start_c: cover property (
    s.rst == usfc_pkg::RX_START && rx_samp && bitv);
  master_clk_c: cover property (s.sync && s.xdir && rise);

endmodule : usfc_core
`default_nettype wire

//--- core/usfc_pkg.sv
// constants and types shared by the serial clock and frame core
package usfc_pkg;
  // register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_CTRL_C = 8'h0C;
  localparam logic [7:0] OFS_BAUD_L = 8'h10;
  localparam logic [7:0] OFS_BAUD_H = 8'h14;
  // serial_control_a fields
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_PE = 2;
  localparam int A_DBL = 1;
  // serial_control_b fields
  localparam int B_XDIR = 5;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_CSZ2 = 2;
  localparam int B_RXB8 = 1;
  localparam int B_TXB8 = 0;
  // serial_control_c fields
  localparam int C_SYNC = 6;
  localparam int C_PM = 4;
  localparam int C_SBS = 3;
  localparam int C_CSZ = 1;
  localparam int C_POL = 0;
  // widths
  localparam int DIV_W = 12;
  localparam int ENT_W = 11;
  // reset values
  localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
  localparam logic [2:0] CSZ_RST = 3'h3;
  // ticks per bit, minus one, and mid-bit sample index
  localparam logic [3:0] RATE_NORM = 4'hF;
  localparam logic [3:0] RATE_DBL = 4'h7;
  localparam logic [3:0] MID_NORM = 4'h9;
  localparam logic [3:0] MID_DBL = 4'h5;
  // frame format codes and receive buffer depth
  localparam logic [2:0] CSZ_9BIT = 3'h7;
  localparam logic [3:0] CSZ_BASE = 4'h5;
  localparam logic [3:0] CSZ_DEF = 4'h8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_DATA = 5'h02,
    TX_PAR = 5'h04,
    TX_STOP = 5'h08,
    TX_LAST = 5'h10
  } usfc_tx_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } usfc_rx_t;

  // number of data bits for a character_size code
  function automatic logic [3:0] usfc_nbits(input logic [2:0] csz);
    if (csz == CSZ_9BIT)
    begin
      return 4'h9;
    end
    else if (csz[2])
    begin
      return CSZ_DEF;
    end
    return CSZ_BASE + {2'h0, csz[1:0]};
  endfunction : usfc_nbits

  // xor of the used data bits, inverted for odd parity
  function automatic logic usfc_parity(input logic [8:0] d,
      input logic [3:0] nb, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
    begin
      if (i < int'(nb))
      begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction : usfc_parity
endpackage : usfc_pkg

//--- test/usfc_peer.sv
// remote serial transceiver model for the far end of the link
`timescale 1ns/100ps
`default_nettype none
module usfc_peer (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic line_i,
  output logic line_o,
  // transfer clock for slave mode
  output logic xck_o
);
  // frame format, kept equal to the device setting by the bench
  int bit_cyc = 32;
  int nb = 8;
  logic pen = 1'b0;
  logic podd = 1'b0;
  logic two = 1'b0;

  // line rests high between frames
  initial line_o = 1'b1;
  // transfer clock stands low outside slave transfers
  initial xck_o = 1'b0;

  // eight system clocks a period keeps it under a quarter of fosc
  task automatic run_clock(input int k);
    repeat (k)
    begin
      xck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      xck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : run_clock

  task automatic put(input logic v);
    line_o <= v;
    repeat (bit_cyc) @(posedge clk_i);
  endtask : put

  // bad_par and bad_stop break a frame on purpose
  task automatic send(input logic [8:0] d, input logic bad_par,
      input logic bad_stop);
    logic p;
    p = podd ^ bad_par;
    @(posedge clk_i);
    put(1'b0); // one start bit
    for (int i = 0; i < nb; i++)
    begin
      put(d[i]); // lsb first
      p = p ^ d[i];
    end
    if (pen)
      put(p); // parity after data
    put(~bad_stop); // stop high
    if (two)
      put(1'b1);
    line_o <= 1'b1;
  endtask : send

  // samples mid-bit; w is the idle wait before the start bit
  task automatic recv(output logic [8:0] d, output logic p,
      output logic s, output int w);
    d = 9'h000;
    p = 1'b0;
    w = 0;
    @(posedge clk_i);
    while (line_i !== 1'b0)
    begin
      @(posedge clk_i);
      w++;
    end
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bit_cyc) @(posedge clk_i);
      d[i] = line_i;
    end
    if (pen)
    begin
      repeat (bit_cyc) @(posedge clk_i);
      p = line_i;
    end
    repeat (bit_cyc) @(posedge clk_i);
    s = line_i;
    if (two)
    begin
      repeat (bit_cyc) @(posedge clk_i);
      s = s & line_i;
    end
  endtask : recv
endmodule : usfc_peer
`default_nettype wire

//--- test/usfc_core_bench.sv
// self-checking bench for the serial clock and frame core
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module usfc_core_bench;
  localparam int LIMIT = 40000;
  localparam int DIVV = 1;
  logic clk;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_s;
  logic sin;
  logic xin;
  logic sout;
  logic xck_o;
  logic xck_oe_n;
  logic txc;
  logic txe;
  logic rxc;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int w;
  int n;
  logic [31:0] q;
  logic [8:0] gd;
  logic gp;
  logic gs;
  logic [8:0] mask;
  logic [8:0] td;
  logic [2:0] csz_tab [4] = '{3'h0, 3'h2, 3'h7, 3'h3};
  logic [1:0] pm_tab [4] = '{2'h3, 2'h2, 2'h0, 2'h2};
  logic sb_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int nb_tab [4] = '{5, 7, 9, 8};
  logic [8:0] d_tab [4] = '{9'h0B5, 9'h14E, 9'h1A3, 9'h0C6};

  usfc_core dut (
    .MCLK_I(clk),
    .NRST_I(rst_n),
    .CE_I(1'b1),
    .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd_s),
    .AVS_WRITE_I(wr_s),
    .AVS_BYTEENABLE_I(4'hF),
    .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_s),
    .SERIAL_IN_I(sin),
    .SERIAL_OUT_O(sout),
    .XFER_CLOCK_I(xin),
    .XFER_CLOCK_O(xck_o),
    .XFER_CLOCK_OE_N_O(xck_oe_n),
    .TX_COMPLETE_O(txc),
    .TX_EMPTY_O(txe),
    .RX_COMPLETE_O(rxc)
  );

  usfc_peer peer (
    .clk_i(clk),
    .line_i(sout),
    .line_o(sin),
    .xck_o(xin)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize;
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      summarize();
    end
  end

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    wr_s <= wr;
    rd_s <= ~wr;
    @(posedge clk);
    while (wait_s !== 1'b0)
      @(posedge clk);
    r = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 8'h00, r);
  endtask : rd

  // cycles between two rising edges of the master transfer clock
  task automatic gap(output int k);
    logic p;
    k = 0;
    p = xck_o;
    @(posedge clk);
    while (!(xck_o === 1'b1 && p === 1'b0))
    begin
      p = xck_o;
      k++;
      @(posedge clk);
    end
  endtask : gap

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(usfc_pkg::OFS_CTRL_A, q);
    `CHK(q, 32'h0000_0020)
    rd(usfc_pkg::OFS_CTRL_C, q);
    `CHK(q, 32'h0000_0006)
    rd(8'h3C, q);
    `CHK(q, 32'h0)
    `CHK(xck_oe_n, 1'b1)
    wr(usfc_pkg::OFS_BAUD_H, 8'hFF);
    rd(usfc_pkg::OFS_BAUD_H, q);
    `CHK(q, 32'h0000_000F)
    wr(usfc_pkg::OFS_BAUD_H, 8'h00);
    wr(usfc_pkg::OFS_BAUD_L, DIVV[7:0]);
    // four formats, the last in double speed, both directions
    for (int i = 0; i < 4; i++)
    begin
      peer.nb = nb_tab[i];
      peer.pen = pm_tab[i][1];
      peer.podd = pm_tab[i][0];
      peer.two = sb_tab[i];
      peer.bit_cyc = (i == 3) ? 8 * (DIVV + 1) : 16 * (DIVV + 1);
      wr(usfc_pkg::OFS_CTRL_A, (i == 3) ? 8'h42 : 8'h40);
      wr(usfc_pkg::OFS_CTRL_C, {2'h0, pm_tab[i], sb_tab[i],
          csz_tab[i][1:0], 1'b0});
      wr(usfc_pkg::OFS_CTRL_B, {3'h0, 2'h3, csz_tab[i][2], 1'b0,
          d_tab[i][8]});
      mask = 9'h1FF >> (9 - nb_tab[i]);
      fork
        peer.recv(gd, gp, gs, w);
        wr(usfc_pkg::OFS_DATA, d_tab[i][7:0]);
      join
      `CHK(gd, d_tab[i] & mask)
      if (pm_tab[i][1])
        `CHK(gp, ^(d_tab[i] & mask) ^ pm_tab[i][0])
      `CHK(gs, 1'b1)
      repeat (peer.bit_cyc) @(posedge clk);
      `CHK(txc, 1'b1)
      `CHK(txe, 1'b1)
      `CHK(xck_oe_n, 1'b1)
      td = (d_tab[i] ^ 9'h1FF) & mask;
      peer.send(td, 1'b0, 1'b0);
      `CHK(rxc, 1'b1)
      rd(usfc_pkg::OFS_CTRL_B, q);
      if (nb_tab[i] == 9)
        `CHK(q[usfc_pkg::B_RXB8], td[8])
      rd(usfc_pkg::OFS_CTRL_A, q);
      `CHK(q[usfc_pkg::A_PE], 1'b0)
      rd(usfc_pkg::OFS_DATA, q);
      `CHK(q[7:0], td[7:0])
    end
    // 8 bits even parity, normal speed
    wr(usfc_pkg::OFS_CTRL_A, 8'h40);
    wr(usfc_pkg::OFS_CTRL_C, 8'h26);
    peer.pen = 1'b1;
    peer.podd = 1'b0;
    peer.two = 1'b0;
    peer.bit_cyc = 16 * (DIVV + 1);
    fork
      begin
        peer.recv(gd, gp, gs, w);
        peer.recv(gd, gp, gs, w);
      end
      begin
        wr(usfc_pkg::OFS_DATA, 8'h3C);
        // a write into a full buffer is dropped, so wait for room
        @(posedge clk);
        while (txe !== 1'b1)
          @(posedge clk);
        wr(usfc_pkg::OFS_DATA, 8'hA5);
      end
    join
    `CHK(gd, 9'h0A5)
    `CHK(w <= peer.bit_cyc / 2 + 2, 1'b1)
    peer.send(9'h05A, 1'b1, 1'b0);
    rd(usfc_pkg::OFS_CTRL_A, q);
    `CHK(q[usfc_pkg::A_PE], 1'b1)
    rd(usfc_pkg::OFS_DATA, q);
    peer.send(9'h033, 1'b0, 1'b1);
    rd(usfc_pkg::OFS_CTRL_A, q);
    `CHK(q[usfc_pkg::A_FE], 1'b1)
    rd(usfc_pkg::OFS_DATA, q);
    // two stop bits set, peer sends one: second never checked
    wr(usfc_pkg::OFS_CTRL_C, 8'h2E);
    peer.send(9'h011, 1'b0, 1'b0);
    peer.send(9'h022, 1'b0, 1'b0);
    peer.send(9'h044, 1'b0, 1'b0);
    rd(usfc_pkg::OFS_CTRL_A, q);
    `CHK(q[usfc_pkg::A_FE], 1'b0)
    `CHK(q[usfc_pkg::A_DOR], 1'b1)
    rd(usfc_pkg::OFS_DATA, q);
    `CHK(q[7:0], 8'h11)
    rd(usfc_pkg::OFS_DATA, q);
    `CHK(q[7:0], 8'h22)
    rd(usfc_pkg::OFS_CTRL_A, q);
    `CHK(q[usfc_pkg::A_DOR], 1'b0)
    `CHK(rxc, 1'b0)
    // synchronous master then slave
    wr(usfc_pkg::OFS_CTRL_C, 8'h46);
    wr(usfc_pkg::OFS_CTRL_B, 8'h28);
    repeat (3) @(posedge clk);
    `CHK(xck_oe_n, 1'b0)
    wr(usfc_pkg::OFS_DATA, 8'h55);
    gap(n);
    gap(n);
    `CHK(n, 2 * (DIVV + 1) - 1)
    wr(usfc_pkg::OFS_CTRL_B, 8'h08);
    repeat (3) @(posedge clk);
    `CHK(xck_oe_n, 1'b1)
    // slave: the frame stays frozen until the partner clocks it out
    wr(usfc_pkg::OFS_CTRL_A, 8'h40);
    wr(usfc_pkg::OFS_DATA, 8'h0F);
    `CHK(txc, 1'b0)
    peer.run_clock(30);
    repeat (4) @(posedge clk);
    `CHK(txc, 1'b1)
    `CHK(txe, 1'b1)
    `CHK(sout, 1'b1)
    summarize();
  end
endmodule : usfc_core_bench
`default_nettype wire
